// File: core/pdm_qualifier.v
`timescale 1ns/1ps
`include "pdm_map.vh"
module pdm_qualifier #(
    parameter DLY_DEPTH = 32
) (
    // Clock, reset, enable
    input wire ref_clk,
    input wire arst_n,
    input wire ce,
    // Command pins, command clock domain
    input wire ck,
    input wire cs_n,
    input wire act_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [1:0] bg,
    input wire [1:0] ba,
    input wire [17:0] addr,
    // Data and termination pins
    input wire dqs,
    input wire dq0,
    input wire odt,
    // Latency configuration, in command clocks
    input wire [4:0] additive_latency,
    input wire [4:0] cas_write_latency,
    // Mode register write towards the register array
    output reg mr_wr_valid,
    output reg [2:0] mr_wr_sel,
    output reg [17:0] mr_wr_data,
    // Status
    output wire per_device_select_mode,
    output reg mrs_dropped,
    output reg foreign_cmd,
    output wire [3:0] parity_latency,
    output wire [1:0] burst_length_on_the_fly,
    // Termination control
    output reg nominal_termination_on,
    output wire park_termination_on,
    output wire dynamic_term_allowed
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT_WL = 2'h1;
    localparam ST_WAIT_DQS = 2'h2;

    wire [30:0] pin_s;
    wire ck_s;
    wire cs_n_s;
    wire act_n_s;
    wire ras_n_s;
    wire cas_n_s;
    wire we_n_s;
    wire [1:0] bg_s;
    wire [1:0] ba_s;
    wire [17:0] addr_s;
    wire dqs_s;
    wire dq0_s;
    wire odt_s;

    pdm_sync #(.W(31)) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .ce(ce),
        .d({ck, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr, dqs, dq0, odt}),
        .q(pin_s)
    );

    assign {ck_s, cs_n_s, act_n_s, ras_n_s, cas_n_s, we_n_s, bg_s, ba_s, addr_s,
        dqs_s, dq0_s, odt_s} = pin_s;

    function [3:0] pl_clocks;
        input [2:0] code;
        begin
            case (code)
                `PDM_PL_CODE_4: pl_clocks = `PDM_PL_CLK_4;
                `PDM_PL_CODE_5: pl_clocks = `PDM_PL_CLK_5;
                `PDM_PL_CODE_6: pl_clocks = `PDM_PL_CLK_6;
                `PDM_PL_CODE_8: pl_clocks = `PDM_PL_CLK_8;
                default: pl_clocks = 4'h0;
            endcase
        end
    endfunction

    reg ck_d_reg;
    reg dqs_d_reg;
    reg mode_reg;
    reg [2:0] pl_code_reg;
    reg [2:0] park_reg;
    reg [2:0] nom_reg;
    reg [1:0] bl_reg;
    reg [1:0] state_reg;
    reg [6:0] lat_cnt_reg;
    reg [1:0] dqs_cnt_reg;
    reg [5:0] tmo_reg;
    reg [2:0] hold_sel_reg;
    reg [17:0] hold_data_reg;
    reg [DLY_DEPTH-1:0] odt_dly_reg;

    wire ck_rise = ck_s & ~ck_d_reg;
    wire dqs_rise = dqs_s & ~dqs_d_reg;
    wire cmd_sel = ck_rise & ~cs_n_s;
    wire is_mrs = cmd_sel & act_n_s & ~ras_n_s & ~cas_n_s & ~we_n_s;
    wire is_other = cmd_sel & ~(act_n_s & ras_n_s & cas_n_s & we_n_s) & ~is_mrs;
    wire [2:0] cmd_mr = {bg_s[0], ba_s};

    // Write position: additive plus write plus parity latency
    wire [6:0] wr_lat = {2'h0, additive_latency} + {2'h0, cas_write_latency}
        + {3'h0, parity_latency};
    wire [6:0] dodt_lat = (wr_lat > `PDM_DODT_OFFSET) ? (wr_lat - `PDM_DODT_OFFSET) : 7'h0;

    assign per_device_select_mode = mode_reg;
    assign parity_latency = pl_clocks(pl_code_reg);
    assign burst_length_on_the_fly = bl_reg;
    assign park_termination_on = (park_reg != 3'h0);
    assign dynamic_term_allowed = ~mode_reg;

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ck_d_reg <= 1'b0;
            dqs_d_reg <= 1'b0;
            mode_reg <= `PDM_MODE_RST;
            pl_code_reg <= `PDM_PL_RST;
            park_reg <= `PDM_TERM_RST;
            nom_reg <= `PDM_TERM_RST;
            bl_reg <= `PDM_BL_RST;
            state_reg <= ST_IDLE;
            lat_cnt_reg <= 7'h0;
            dqs_cnt_reg <= 2'h0;
            tmo_reg <= 6'h0;
            hold_sel_reg <= 3'h0;
            hold_data_reg <= 18'h0;
            mr_wr_valid <= 1'b0;
            mr_wr_sel <= 3'h0;
            mr_wr_data <= 18'h0;
            mrs_dropped <= 1'b0;
            foreign_cmd <= 1'b0;
            odt_dly_reg <= {DLY_DEPTH{1'b0}};
            nominal_termination_on <= 1'b0;
        end
        else if (ce)
        begin
            ck_d_reg <= ck_s;
            dqs_d_reg <= dqs_s;
            mr_wr_valid <= 1'b0;
            mrs_dropped <= 1'b0;
            foreign_cmd <= mode_reg & is_other;
            if (ck_rise)
                odt_dly_reg <= {odt_dly_reg[DLY_DEPTH-2:0], odt_s};
            // Termination pin steers nominal termination at direct latency
            if (nom_reg == 3'h0)
                nominal_termination_on <= 1'b0;
            else if (dodt_lat == 7'h0)
                nominal_termination_on <= odt_s;
            else
                nominal_termination_on <= odt_dly_reg[dodt_lat[4:0] - 5'h1];
            case (state_reg)
                ST_IDLE:
                begin
                    if (is_mrs)
                    begin
                        hold_sel_reg <= cmd_mr;
                        hold_data_reg <= addr_s;
                        if (mode_reg)
                        begin
                            // Qualifying transfer follows at the write position
                            lat_cnt_reg <= wr_lat;
                            dqs_cnt_reg <= 2'h0;
                            tmo_reg <= `PDM_CAP_TIMEOUT;
                            state_reg <= ST_WAIT_WL;
                        end
                        else
                        begin
                            mr_wr_valid <= 1'b1;
                            mr_wr_sel <= cmd_mr;
                            mr_wr_data <= addr_s;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_WAIT_WL:
                begin
                    if (ck_rise)
                    begin
                        if (lat_cnt_reg <= 7'h1)
                            state_reg <= ST_WAIT_DQS;
                        else
                            lat_cnt_reg <= lat_cnt_reg - 7'h1;
                    end
                end
                ST_WAIT_DQS:
                begin
                    if (ck_rise)
                        tmo_reg <= tmo_reg - 6'h1;
                    if (dqs_rise)
                    begin
                        dqs_cnt_reg <= dqs_cnt_reg + 2'h1;
                        // Second rising edge covers both chopped and full bursts
                        if (dqs_cnt_reg + 2'h1 == `PDM_DQS_CAPTURE_EDGE)
                        begin
                            state_reg <= ST_IDLE;
                            if (!dq0_s)
                            begin
                                mr_wr_valid <= 1'b1;
                                mr_wr_sel <= hold_sel_reg;
                                mr_wr_data <= hold_data_reg;
                            end
                            else
                                mrs_dropped <= 1'b1;
                        end
                    end
                    else if (ck_rise && tmo_reg == 6'h1)
                    begin
                        mrs_dropped <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
            // Shadow the fields this block needs when a write takes effect
            if (mr_wr_valid)
            begin
                case (mr_wr_sel)
                    `PDM_MR3: mode_reg <= mr_wr_data[`PDM_MR3_MODE_BIT];
                    `PDM_MR5:
                    begin
                        pl_code_reg <= mr_wr_data[`PDM_MR5_PL_LSB +: 3];
                        park_reg <= mr_wr_data[`PDM_MR5_PARK_LSB +: 3];
                    end
                    `PDM_MR1: nom_reg <= mr_wr_data[`PDM_MR1_NOM_LSB +: 3];
                    `PDM_MR0: bl_reg <= mr_wr_data[`PDM_MR0_BL_LSB +: 2];
                    default: bl_reg <= bl_reg;
                endcase
            end
        end
    end
endmodule

// File: core/pdm_map.vh
// What this block does
// - Latch lane 0 on second rising strobe edge
// - Fixed and on-the-fly burst lengths both accepted
// - Mode register 3 bit 4 enters; resets 0
// - Lane 0 low executes, high discards MRS
// - Writing bit 4 to zero exits mode
// - Exit rewrites register 3 wholly, harmless
// - Lane 0 captured by strobe like writes
// - No dynamic termination while mode active
// - Termination pin drives nominal termination in mode
// - Parity latency from register 5 bits 2:0
`ifndef PDM_MAP_VH
`define PDM_MAP_VH

// Mode register select codes
`define PDM_MR0 3'h0
`define PDM_MR1 3'h1
`define PDM_MR3 3'h3
`define PDM_MR5 3'h5

// Field positions
`define PDM_MR3_MODE_BIT 4
`define PDM_MR5_PL_LSB 0
`define PDM_MR5_PARK_LSB 6
`define PDM_MR1_NOM_LSB 8
`define PDM_MR0_BL_LSB 0

// Reset values
`define PDM_MODE_RST 1'h0
`define PDM_PL_RST 3'h0
`define PDM_TERM_RST 3'h0
`define PDM_BL_RST 2'h0

// Parity latency codes and clock counts
`define PDM_PL_CODE_OFF 3'h0
`define PDM_PL_CODE_4 3'h1
`define PDM_PL_CODE_5 3'h2
`define PDM_PL_CODE_6 3'h3
`define PDM_PL_CODE_8 3'h4
`define PDM_PL_CLK_4 4'h4
`define PDM_PL_CLK_5 4'h5
`define PDM_PL_CLK_6 4'h6
`define PDM_PL_CLK_8 4'h8

// Strobe edge that carries the qualifying bit
`define PDM_DQS_CAPTURE_EDGE 2'h2
// Command clocks to wait for the strobe before dropping the command
`define PDM_CAP_TIMEOUT 6'h10
// Direct turn-on/off latency is write latency minus this many clocks
`define PDM_DODT_OFFSET 7'h02

`endif

// File: core/pdm_sync.v
`timescale 1ns/1ps
module pdm_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    input wire ce,
    // Data
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end
        else if (ce)
        begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

// File: testbench/pdm_qualifier_monitor.sv
`timescale 1ns/1ps
module pdm_qualifier_monitor (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // Observed outputs
    input wire mr_wr_valid,
    input wire [2:0] mr_wr_sel,
    input wire [17:0] mr_wr_data,
    input wire per_device_select_mode,
    input wire mrs_dropped,
    input wire foreign_cmd,
    input wire [3:0] parity_latency,
    input wire dynamic_term_allowed
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence mr3_write;
        mr_wr_valid && mr_wr_sel == 3'h3;
    endsequence
    mode_set_a: assert property (
        mr3_write |=> per_device_select_mode == $past(mr_wr_data[4]))
        else $error("mode bit wrong");
    mode_cause_a: assert property (
        $changed(per_device_select_mode) |-> $past(mr_wr_valid)) else $error("mode bit moved");
    wr_excl_a: assert property (
        !(mr_wr_valid && mrs_dropped)) else $error("write and drop");
    wr_pulse_a: assert property (
        mr_wr_valid |=> !mr_wr_valid) else $error("long write pulse");
    drop_mode_a: assert property (
        mrs_dropped |-> per_device_select_mode) else $error("drop off mode");
    foreign_mode_a: assert property (
        foreign_cmd |-> per_device_select_mode) else $error("bad flag");
    dyn_term_a: assert property (
        dynamic_term_allowed == !per_device_select_mode) else $error("dynamic term in mode");
    pl_code_a: assert property (
        parity_latency inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h8}) else $error("bad parity latency");
    sel_hold_a: assert property (
        !mr_wr_valid |-> $stable(mr_wr_sel)) else $error("sel moved");
endmodule

// File: testbench/pdm_ctrl_model.sv
`timescale 1ns/1ps
module pdm_ctrl_model (
    // Clock and latency
    input wire ref_clk,
    input wire [4:0] wl,
    // Command pins
    output reg ck,
    output reg cs_n,
    output reg act_n,
    output reg ras_n,
    output reg cas_n,
    output reg we_n,
    output reg [1:0] bg,
    output reg [1:0] ba,
    output reg [17:0] addr,
    // Data pins
    output reg dqs,
    output reg dq0
);
    reg [2:0] div = 3'h0;
    initial {ck, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr, dqs, dq0} = {6'h1f, 22'h0, 2'h1};
    // Command clock runs free at 64 ns
    always @(posedge ref_clk)
    begin
        div <= div + 3'h1;
        if (div == 3'h7)
            ck <= ~ck;
    end
    task cmd(input [3:0] kind, input [2:0] sel, input [17:0] d, input q, input strobe);
        integer i;
        begin
            @(negedge ck);
            cs_n <= 1'b0;
            {act_n, ras_n, cas_n, we_n} <= kind;
            {bg, ba} <= {1'b0, sel};
            addr <= d;
            dq0 <= q;
            @(negedge ck);
            cs_n <= 1'b1;
            {act_n, ras_n, cas_n, we_n} <= 4'hf;
            addr <= ~d;
            if (strobe)
            begin
                // Strobe lands at the write position, as leveling has aligned it
                repeat (wl) @(posedge ck);
                for (i = 0; i < 8; i = i + 1)
                begin
                    @(ck);
                    dqs <= ~dqs;
                end
            end
            dq0 <= ~q;
        end
    endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    reg ref_clk, arst_n, odt, q, odt_hold, odt_lvl;
    reg [17:0] d;
    reg [1:0] bl;
    wire ck, cs_n, act_n, ras_n, cas_n, we_n, dqs, dq0, mr_wr_valid, mrs_dropped, foreign_cmd;
    wire per_device_select_mode, park_term, nom_term, dynamic_term_allowed;
    wire [1:0] bg, ba, burst_length_on_the_fly;
    wire [17:0] addr, mr_wr_data;
    wire [2:0] mr_wr_sel;
    wire [3:0] parity_latency;
    integer mismatches, total_checks, seed, n_wr, n_drop, n_for, exp_drop, k;
    pdm_ctrl_model u_pdm_ctrl_model (.ref_clk(ref_clk), .wl(5'h09), .ck(ck), .cs_n(cs_n),
        .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba),
        .addr(addr), .dqs(dqs), .dq0(dq0));
    pdm_qualifier u_pdm_qualifier (.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .ck(ck),
        .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg),
        .ba(ba), .addr(addr), .dqs(dqs), .dq0(dq0), .odt(odt), .additive_latency(5'h00),
        .cas_write_latency(5'h09), .mr_wr_valid(mr_wr_valid), .mr_wr_sel(mr_wr_sel),
        .mr_wr_data(mr_wr_data), .per_device_select_mode(per_device_select_mode),
        .mrs_dropped(mrs_dropped), .foreign_cmd(foreign_cmd), .parity_latency(parity_latency),
        .burst_length_on_the_fly(burst_length_on_the_fly), .nominal_termination_on(nom_term),
        .park_termination_on(park_term), .dynamic_term_allowed(dynamic_term_allowed));
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        odt <= odt_hold ? odt_lvl : $random(seed);
        n_wr <= n_wr + (mr_wr_valid === 1'b1);
        n_drop <= n_drop + (mrs_dropped === 1'b1);
        n_for <= n_for + (foreign_cmd === 1'b1);
    end
    function [3:0] pl_clk(input [2:0] c);
        pl_clk = (c == 3'h1) ? 4'h4 : (c == 3'h2) ? 4'h5 : (c == 3'h3) ? 4'h6
            : (c == 3'h4) ? 4'h8 : 4'h0;
    endfunction
    task chk(input [8*8:1] nm, input [17:0] e, input [17:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e)
            begin
                mismatches = mismatches + 1;
                $display("[ERR] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", total_checks, mismatches);
            if (mismatches == 0 && total_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Issues one command and waits for it to be executed or discarded, then keeps spacing
    task run(input [3:0] kind, input [2:0] sel, input [17:0] dv, input qv, input strobe);
        integer s, j;
        begin
            s = n_wr + n_drop;
            u_pdm_ctrl_model.cmd(kind, sel, dv, qv, strobe);
            for (j = 0; j < 3000 && n_wr + n_drop == s; j = j + 1)
                @(posedge ref_clk);
            chk("answer", 18'h1, n_wr + n_drop - s);
            if (n_wr + n_drop == s)
                conclude;
            repeat (64) @(posedge ref_clk);
        end
    endtask
    initial
    begin
        {mismatches, total_checks, n_wr, n_drop, n_for, exp_drop} = 0;
        seed = 37;
        arst_n = 1'b0;
        odt_hold = 1'b0;
        odt_lvl = 1'b0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("mode", 18'h0, per_device_select_mode);
        chk("dynterm", 18'h1, dynamic_term_allowed);
        for (k = 4; k >= 0; k = k - 1)
        begin
            d = $random(seed);
            d[2:0] = k;
            run(4'h8, 3'h5, d, 1'b1, 1'b0);
            chk("parlat", pl_clk(k), parity_latency);
            chk("park", |d[8:6], park_term);
        end
        $display("test config done");
        run(4'h8, 3'h3, 18'h10, 1'b0, 1'b0);
        chk("mode", 18'h1, per_device_select_mode);
        chk("dynterm", 18'h0, dynamic_term_allowed);
        bl = burst_length_on_the_fly;
        for (k = 0; k < 6; k = k + 1)
        begin
            d = $random(seed);
            q = (k < 2) ? k : $random(seed);
            run(4'h8, 3'h0, d, q, 1'b1);
            bl = q ? bl : d[1:0];
            exp_drop = exp_drop + q;
            chk("burst", bl, burst_length_on_the_fly);
        end
        run(4'h8, 3'h0, {16'h0, ~bl}, 1'b0, 1'b0);
        chk("burst", bl, burst_length_on_the_fly);
        k = n_for;
        u_pdm_ctrl_model.cmd(4'h7, 3'h0, 18'h0, 1'b1, 1'b0);
        repeat (64) @(posedge ref_clk);
        chk("foreign", k + 1, n_for);
        // Nominal termination off: random pin level must not reach the output
        chk("nomterm", 18'h0, nom_term);
        run(4'h8, 3'h1, 18'h100, 1'b0, 1'b1);
        odt_hold <= 1'b1;
        odt_lvl <= 1'b0;
        repeat (128) @(posedge ref_clk);
        chk("nomterm", 18'h0, nom_term);
        // Pin rises; output follows only after the direct latency of 7 command clocks
        odt_lvl <= 1'b1;
        repeat (48) @(posedge ref_clk);
        chk("nomterm", 18'h0, nom_term);
        repeat (80) @(posedge ref_clk);
        chk("nomterm", 18'h1, nom_term);
        odt_hold <= 1'b0;
        $display("test mode done");
        run(4'h8, 3'h3, 18'h0, 1'b1, 1'b1);
        chk("mode", 18'h1, per_device_select_mode);
        run(4'h8, 3'h3, 18'h0, 1'b0, 1'b1);
        chk("mode", 18'h0, per_device_select_mode);
        chk("dynterm", 18'h1, dynamic_term_allowed);
        chk("drops", exp_drop + 2, n_drop);
        $display("test exit done");
        conclude;
    end
endmodule
bind pdm_qualifier pdm_qualifier_monitor u_mon (.ref_clk(ref_clk), .arst_n(arst_n),
    .mr_wr_valid(mr_wr_valid), .mr_wr_sel(mr_wr_sel), .mr_wr_data(mr_wr_data),
    .per_device_select_mode(per_device_select_mode), .mrs_dropped(mrs_dropped),
    .foreign_cmd(foreign_cmd), .parity_latency(parity_latency),
    .dynamic_term_allowed(dynamic_term_allowed));
